// ==== src/lic_compat_core.sv ====
// Purpose: Mode control, status word, exit frames and register/address mapping for compatibility mode
// Assumes: All inputs come from pipeline logic on sys_clk
// Notes: Instruction semantics and native exception dispatch live in the host pipeline
module lic_compat_core
    import lic_pkg::*;
(
    input wire logic sys_clk, // 20 MHz clock
    input wire logic reset, // Async reset, active high
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic rei_valid, // Native return-from-exception executing
    input wire logic [31:0] rei_psl, // Popped status longword image
    input wire logic [31:0] rei_pc, // Popped PC image
    input wire logic instr_valid, // Legacy instruction word presented
    input wire logic [15:0] instr_word, // Legacy instruction word
    input wire logic [15:0] instr_pc, // Legacy PC of that instruction
    input wire logic ret_psw_valid, // RETURN_FROM_INTERRUPT_OP/RETURN_FROM_TRACE_TRAP_OP popped status word
    input wire logic [15:0] ret_psw, // Popped status word image
    input wire logic src_valid, // Source operand fetched
    input wire logic [15:0] src_value, // Source operand value
    input wire logic ea_valid, // Memory operand address computed
    input wire logic [15:0] ea_addr, // Legacy byte address
    input wire logic ea_is_word, // Access is a word reference
    input wire logic exc_req, // Exception, interrupt or paging fault
    input wire logic [2:0] leg_reg_sel, // Legacy register number
    input wire logic [15:0] leg_wr_data, // Legacy register write data
    input wire logic [31:0] native_rd_data, // Native register read data
    output logic compat_mode, // Legacy decoding active
    output logic [15:0] compat_status_word, // Legacy status word
    output logic instr_exec, // Instruction accepted for hardware execution
    output logic byte_op, // Accepted instruction is a byte form
    output logic stack_push, // Push on current stack via R6
    output logic stack_pop, // Pop from current stack via R6
    output logic rsvd_operand_fault, // Entry refused
    output logic frame_valid, // Exit frame ready for native dispatch
    output logic [31:0] frame_psl, // Stacked status longword
    output logic [31:0] frame_pc, // Stacked PC
    output logic [31:0] frame_code, // Trap code longword
    output logic frame_has_code, // Three-longword frame
    output logic [15:0] src_operand, // Held source operand
    output logic [15:0] jump_target, // Captured new PC of a jump
    output logic [31:0] virt_addr, // Per-process virtual address
    output logic [3:0] native_reg_sel, // Mapped native register number
    output logic [31:0] native_wr_data, // Zero-extended native write data
    output logic [15:0] leg_rd_data // Low half of native read data
);
    lic_dec_if dif();
    lic_state_t state_r, state_nxt;
    logic [PSW_KEEP_W-1:0] psw_r, psw_nxt;
    logic exec_r, exec_nxt, byte_r, byte_nxt, push_r, push_nxt, pop_r, pop_nxt;
    logic fault_r, fault_nxt, fv_r, fv_nxt, fcode_r, fcode_nxt;
    logic [31:0] fpsl_r, fpsl_nxt, fpc_r, fpc_nxt, fcw_r, fcw_nxt;
    logic [15:0] src_r, src_nxt, jt_r, jt_nxt, lrd_r, lrd_nxt;
    logic jpend_r, jpend_nxt;
    logic [31:0] va_r, va_nxt, nwd_r, nwd_nxt;
    logic [3:0] nsel_r, nsel_nxt;
    logic entry_ok, odd_addr;

    // Opcode classifier
    assign dif.word = instr_word;
    lic_opcode_decode u_dec (
        .dif(dif)
    );

    // Status longword checks on entry
    always_comb
    begin
        entry_ok = (rei_psl[PSL_CHK_MSB:PSL_CHK_LSB] == '0)
            && (rei_psl[PSL_IPL_MSB:PSL_IPL_LSB] == '0)
            && !rei_psl[PSL_IS_BIT] && !rei_psl[PSL_FPD_BIT]
            && (rei_psl[PSL_CUR_MSB:PSL_CUR_LSB] == USER_MODE)
            && (rei_psl[PSL_PRV_MSB:PSL_PRV_LSB] == USER_MODE);
        odd_addr = ea_valid && ea_is_word && ea_addr[0];
    end

    // Mode, status word and exit frame next state
    always_comb
    begin
        state_nxt = state_r;
        psw_nxt = psw_r;
        exec_nxt = 1'b0;
        byte_nxt = byte_r;
        push_nxt = 1'b0;
        pop_nxt = 1'b0;
        fault_nxt = 1'b0;
        fv_nxt = 1'b0;
        fcode_nxt = fcode_r;
        fpsl_nxt = fpsl_r;
        fpc_nxt = fpc_r;
        fcw_nxt = fcw_r;
        case (state_r)
            ST_NATIVE:
            begin
                if (rei_valid && rei_psl[PSL_CM_BIT])
                begin
                    if (entry_ok)
                    begin
                        state_nxt = ST_COMPAT;
                        psw_nxt = rei_psl[PSW_KEEP_W-1:0];
                    end
                    else
                        fault_nxt = 1'b1;
                end
            end
            ST_COMPAT:
            begin
                if (exc_req || odd_addr || (instr_valid && dif.cls != CLS_EXEC))
                begin
                    // Leave; frame never touches R6, kernel stack is native's job
                    state_nxt = ST_NATIVE;
                    fv_nxt = 1'b1;
                    fcode_nxt = !exc_req;
                    fpsl_nxt = 32'h0000_0000;
                    fpsl_nxt[PSL_CM_BIT] = 1'b1;
                    fpsl_nxt[PSL_TP_BIT] = !exc_req && psw_r[PSW_T_BIT];
                    fpsl_nxt[PSL_CUR_MSB:PSL_CUR_LSB] = USER_MODE;
                    fpsl_nxt[PSL_PRV_MSB:PSL_PRV_LSB] = USER_MODE;
                    fpsl_nxt[PSW_KEEP_W-1:0] = psw_r;
                    fpc_nxt = {16'h0000, instr_pc};
                    fcw_nxt = {16'h0000, (exc_req ? TRAP_RSVD : (odd_addr ? TRAP_ODD : dif.trap_code))};
                end
                else if (instr_valid)
                begin
                    exec_nxt = 1'b1;
                    byte_nxt = dif.byte_op;
                    push_nxt = dif.push_op;
                    pop_nxt = dif.pop_op;
                    if (dif.cc_op && instr_word[4])
                        psw_nxt[3:0] = psw_r[3:0] | instr_word[3:0];
                    else if (dif.cc_op)
                        psw_nxt[3:0] = psw_r[3:0] & ~instr_word[3:0];
                end
                else if (ret_psw_valid)
                    psw_nxt = ret_psw[PSW_KEEP_W-1:0];
            end
            default: state_nxt = ST_NATIVE;
        endcase
    end

    // Control registers
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= ST_NATIVE;
            psw_r <= PSW_RESET;
            exec_r <= 1'b0;
            byte_r <= 1'b0;
            push_r <= 1'b0;
            pop_r <= 1'b0;
            fault_r <= 1'b0;
            fv_r <= 1'b0;
            fcode_r <= 1'b0;
            fpsl_r <= 32'h0000_0000;
            fpc_r <= 32'h0000_0000;
            fcw_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            psw_r <= psw_nxt;
            exec_r <= exec_nxt;
            byte_r <= byte_nxt;
            push_r <= push_nxt;
            pop_r <= pop_nxt;
            fault_r <= fault_nxt;
            fv_r <= fv_nxt;
            fcode_r <= fcode_nxt;
            fpsl_r <= fpsl_nxt;
            fpc_r <= fpc_nxt;
            fcw_r <= fcw_nxt;
        end
    end

    // Operand, jump target and mapping next state
    always_comb
    begin
        src_nxt = src_valid ? src_value : src_r;
        jpend_nxt = jpend_r;
        jt_nxt = jt_r;
        if (state_r == ST_COMPAT && instr_valid && dif.cls == CLS_EXEC && dif.jump_op)
            jpend_nxt = 1'b1;
        else if (jpend_r && ea_valid)
        begin
            jt_nxt = ea_addr;
            jpend_nxt = 1'b0;
        end
        va_nxt = ea_valid ? {16'h0000, ea_addr} : va_r;
        nsel_nxt = (leg_reg_sel == LEG_PC_IDX) ? NATIVE_PC_IDX : {1'b0, leg_reg_sel};
        nwd_nxt = {16'h0000, leg_wr_data};
        lrd_nxt = native_rd_data[15:0];
    end

    // Datapath registers
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            src_r <= 16'h0000;
            jt_r <= 16'h0000;
            jpend_r <= 1'b0;
            va_r <= 32'h0000_0000;
            nsel_r <= 4'h0;
            nwd_r <= 32'h0000_0000;
            lrd_r <= 16'h0000;
        end
        else if (ce)
        begin
            src_r <= src_nxt;
            jt_r <= jt_nxt;
            jpend_r <= jpend_nxt;
            va_r <= va_nxt;
            nsel_r <= nsel_nxt;
            nwd_r <= nwd_nxt;
            lrd_r <= lrd_nxt;
        end
    end

    // Outputs
    assign compat_mode = (state_r == ST_COMPAT);
    assign compat_status_word = {{(PSW_W-PSW_KEEP_W){1'b0}}, psw_r};
    assign instr_exec = exec_r;
    assign byte_op = byte_r;
    assign stack_push = push_r;
    assign stack_pop = pop_r;
    assign rsvd_operand_fault = fault_r;
    assign frame_valid = fv_r;
    assign frame_psl = fpsl_r;
    assign frame_pc = fpc_r;
    assign frame_code = fcw_r;
    assign frame_has_code = fcode_r;
    assign src_operand = src_r;
    assign jump_target = jt_r;
    assign virt_addr = va_r;
    assign native_reg_sel = nsel_r;
    assign native_wr_data = nwd_r;
    assign leg_rd_data = lrd_r;
endmodule // lic_compat_core

// ==== src/lic_dec_if.sv ====
// Purpose: Carries an instruction word to the opcode classifier and its result back
// Assumes: Classifier is purely combinational
// Notes: Field outputs are the octal mode and register digits
interface lic_dec_if;
    import lic_pkg::*;
    logic [15:0] word;
    lic_class_t cls;
    logic [15:0] trap_code;
    logic byte_op;
    logic cc_op;
    logic ret_op;
    logic push_op;
    logic pop_op;
    logic jump_op;
    logic [2:0] src_mode;
    logic [2:0] src_reg;
    logic [2:0] dst_mode;
    logic [2:0] dst_reg;
    modport dec (input word, output cls, trap_code, byte_op, cc_op, ret_op, push_op, pop_op, jump_op,
        src_mode, src_reg, dst_mode, dst_reg);
    modport ctl (output word, input cls, trap_code, byte_op, cc_op, ret_op, push_op, pop_op, jump_op,
        src_mode, src_reg, dst_mode, dst_reg);
endinterface

// ==== src/lic_opcode_decode.sv ====
// Purpose: Classifies a legacy instruction word as executed, trapping or reserved
// Assumes: Word is stable while it is examined
// Notes: Byte selector is bit 15 only for instructions with byte forms
module lic_opcode_decode
    import lic_pkg::*;
(
    lic_dec_if.dec dif // Word in, class out
);
    // Octal operand fields
    assign dif.src_mode = dif.word[11:9];
    assign dif.src_reg = dif.word[8:6];
    assign dif.dst_mode = dif.word[5:3];
    assign dif.dst_reg = dif.word[2:0];

    // Opcode classification
    always_comb
    begin
        dif.cls = CLS_RSVD;
        dif.trap_code = TRAP_RSVD;
        dif.byte_op = 1'b0;
        dif.cc_op = 1'b0;
        dif.ret_op = 1'b0;
        dif.push_op = 1'b0;
        dif.pop_op = 1'b0;
        dif.jump_op = 1'b0;
        case (dif.word[14:12])
            3'h0:
            begin
                if (dif.word[11] == 1'b0 && (dif.word[15] || dif.word[10:8] != 3'h0))
                    dif.cls = CLS_EXEC;
                else if (dif.word[11] == 1'b0)
                begin
                    case (dif.word[7:6])
                        2'h0:
                        begin
                            if (dif.word[5:3] == 3'h0 && (dif.word[2:0] == OP_RTI || dif.word[2:0] == OP_RTT))
                            begin
                                dif.cls = CLS_EXEC;
                                dif.ret_op = 1'b1;
                            end
                            else if (dif.word[5:3] == 3'h0 && dif.word[2:0] == OP_BPT)
                            begin
                                dif.cls = CLS_SOFT;
                                dif.trap_code = TRAP_BPT;
                            end
                            else if (dif.word[5:3] == 3'h0 && dif.word[2:0] == OP_IOT)
                            begin
                                dif.cls = CLS_SOFT;
                                dif.trap_code = TRAP_IOT;
                            end
                        end
                        2'h1:
                        begin
                            dif.jump_op = 1'b1;
                            dif.cls = (dif.word[5:3] == MODE_REG) ? CLS_ILL : CLS_EXEC;
                            dif.trap_code = (dif.word[5:3] == MODE_REG) ? TRAP_ILL : TRAP_RSVD;
                        end
                        2'h2:
                        begin
                            if (dif.word[5:3] == 3'h0)
                                dif.cls = CLS_EXEC;
                            else if (dif.word[5])
                            begin
                                dif.cls = CLS_EXEC;
                                dif.cc_op = 1'b1;
                            end
                        end
                        default: dif.cls = CLS_EXEC;
                    endcase
                end
                else
                begin
                    case (dif.word[11:9])
                        GRP_JSR:
                        begin
                            if (!dif.word[15])
                            begin
                                dif.jump_op = 1'b1;
                                dif.cls = (dif.word[5:3] == MODE_REG) ? CLS_ILL : CLS_EXEC;
                                dif.trap_code = (dif.word[5:3] == MODE_REG) ? TRAP_ILL : TRAP_RSVD;
                            end
                            else
                            begin
                                dif.cls = CLS_SOFT;
                                dif.trap_code = dif.word[8] ? TRAP_SWT : TRAP_EMT;
                            end
                        end
                        GRP_SINGLE:
                        begin
                            dif.cls = CLS_EXEC;
                            dif.byte_op = dif.word[15];
                        end
                        GRP_EXT:
                        begin
                            case (dif.word[8:6])
                                EXT_MARK: dif.cls = CLS_RSVD;
                                EXT_PUSH:
                                begin
                                    dif.cls = CLS_EXEC;
                                    dif.push_op = 1'b1;
                                end
                                EXT_POP:
                                begin
                                    dif.cls = CLS_EXEC;
                                    dif.pop_op = 1'b1;
                                end
                                EXT_SXT: dif.cls = dif.word[15] ? CLS_RSVD : CLS_EXEC;
                                default:
                                begin
                                    dif.cls = CLS_EXEC;
                                    dif.byte_op = dif.word[15];
                                end
                            endcase
                        end
                        default: dif.cls = CLS_RSVD;
                    endcase
                end
            end
            3'h6: dif.cls = CLS_EXEC;
            GRP_EIS:
            begin
                if (dif.word[15] || dif.word[11:9] == EIS_FLOAT || dif.word[11:9] == EIS_SPARE)
                    dif.cls = CLS_RSVD;
                else
                    dif.cls = CLS_EXEC;
            end
            default:
            begin
                dif.cls = CLS_EXEC;
                dif.byte_op = dif.word[15];
            end
        endcase
    end
endmodule // lic_opcode_decode

// ==== src/lic_pkg.sv ====
// Purpose: Shared constants and types for the legacy 16-bit compatibility mode
// Assumes: Native status longword layout with the legacy status word in bits 15..0
// Notes: Opcode groups are octal digit fields of the 16-bit instruction word
package lic_pkg;
    // Legacy status word layout
    localparam int PSW_W = 16;
    localparam int PSW_KEEP_W = 5;
    localparam int PSW_T_BIT = 4;
    localparam logic [PSW_KEEP_W-1:0] PSW_RESET = 5'h00;
    // Native status longword field positions
    localparam int PSL_CM_BIT = 31;
    localparam int PSL_TP_BIT = 30;
    localparam int PSL_FPD_BIT = 27;
    localparam int PSL_IS_BIT = 26;
    localparam int PSL_CUR_MSB = 25;
    localparam int PSL_CUR_LSB = 24;
    localparam int PSL_PRV_MSB = 23;
    localparam int PSL_PRV_LSB = 22;
    localparam int PSL_IPL_MSB = 20;
    localparam int PSL_IPL_LSB = 16;
    localparam int PSL_CHK_MSB = 15;
    localparam int PSL_CHK_LSB = 5;
    localparam logic [1:0] USER_MODE = 2'h3;
    // Trap codes in the third frame longword
    localparam logic [15:0] TRAP_RSVD = 16'h0000;
    localparam logic [15:0] TRAP_BPT = 16'h0001;
    localparam logic [15:0] TRAP_IOT = 16'h0002;
    localparam logic [15:0] TRAP_EMT = 16'h0003;
    localparam logic [15:0] TRAP_SWT = 16'h0004;
    localparam logic [15:0] TRAP_ILL = 16'h0005;
    localparam logic [15:0] TRAP_ODD = 16'h0006;
    // Register mapping
    localparam logic [2:0] LEG_PC_IDX = 3'h7;
    localparam logic [3:0] NATIVE_PC_IDX = 4'hF;
    // Octal opcode digit values
    localparam logic [2:0] GRP_JSR = 3'h4;
    localparam logic [2:0] GRP_SINGLE = 3'h5;
    localparam logic [2:0] GRP_EXT = 3'h6;
    localparam logic [2:0] GRP_EIS = 3'h7;
    localparam logic [2:0] EXT_MARK = 3'h4;
    localparam logic [2:0] EXT_PUSH = 3'h5;
    localparam logic [2:0] EXT_POP = 3'h6;
    localparam logic [2:0] EXT_SXT = 3'h7;
    localparam logic [2:0] EIS_FLOAT = 3'h5;
    localparam logic [2:0] EIS_SPARE = 3'h6;
    localparam logic [2:0] OP_RTI = 3'h2;
    localparam logic [2:0] OP_BPT = 3'h3;
    localparam logic [2:0] OP_IOT = 3'h4;
    localparam logic [2:0] OP_RTT = 3'h6;
    localparam logic [2:0] MODE_REG = 3'h0;
    typedef enum logic [1:0] {
        CLS_EXEC = 2'b00,
        CLS_SOFT = 2'b01,
        CLS_RSVD = 2'b10,
        CLS_ILL = 2'b11
    } lic_class_t;
    typedef enum logic [0:0] {
        ST_NATIVE = 1'b0,
        ST_COMPAT = 1'b1
    } lic_state_t;
endpackage

// ==== verification/legacy_isa_compat_mode_tb.sv ====
// Purpose: Self-checking bench for the compatibility core
// Assumes: 50 ns clock, reset held 12 cycles
// Notes: Executive model supplies every entry
module legacy_isa_compat_mode_tb;
    import lic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] GOOD = 32'h83C0000A;
    logic sys_clk, reset, go, rei_valid, instr_valid, ret_psw_valid, ea_valid, ea_is_word, exc_req;
    logic compat_mode, instr_exec, byte_op, stack_push, stack_pop, rsvd_operand_fault;
    logic frame_valid, frame_has_code;
    logic [2:0] leg_reg_sel;
    logic [3:0] go_dly, native_reg_sel;
    logic [15:0] instr_word, ret_psw, ea_addr, leg_wr_data;
    logic [15:0] compat_status_word, src_operand, jump_target, leg_rd_data;
    logic [31:0] go_psl, rei_psl, native_rd_data, frame_psl, frame_pc, frame_code, virt_addr, native_wr_data;
    int num_errors, check_count;
    lic_exec_model u_exec (.sys_clk, .go, .go_psl, .go_dly, .rei_valid, .rei_psl);
    lic_compat_core uut (.sys_clk, .reset, .ce(1'b1), .rei_valid, .rei_psl, .rei_pc(32'h00000000),
        .instr_valid, .instr_word, .instr_pc(16'h1234), .ret_psw_valid, .ret_psw, .src_valid(1'b0),
        .src_value(16'h0000), .ea_valid, .ea_addr, .ea_is_word, .exc_req, .leg_reg_sel, .leg_wr_data,
        .native_rd_data, .compat_mode, .compat_status_word, .instr_exec, .byte_op, .stack_push,
        .stack_pop, .rsvd_operand_fault, .frame_valid, .frame_psl, .frame_pc, .frame_code,
        .frame_has_code, .src_operand, .jump_target, .virt_addr, .native_reg_sel, .native_wr_data,
        .leg_rd_data);
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Ask the executive for a return, wait for the taking edge
    task automatic enter(logic [31:0] p, logic [3:0] d);
        @(posedge sys_clk);
        {go, go_psl, go_dly} <= {1'b1, p, d};
        @(posedge sys_clk);
        go <= 1'b0;
        for (int i = 0; i < 20 && rei_valid !== 1'b1; i++)
            @(posedge sys_clk);
        #1;
    endtask
    task automatic instr(logic [15:0] w);
        @(posedge sys_clk);
        {instr_valid, instr_word} <= {1'b1, w};
        @(posedge sys_clk);
        {instr_valid, instr_word} <= {1'b0, ~w};
        #1;
    endtask
    task automatic ea(logic [15:0] a, logic w);
        @(posedge sys_clk);
        {ea_valid, ea_addr, ea_is_word} <= {1'b1, a, w};
        @(posedge sys_clk);
        ea_valid <= 1'b0;
        #1;
    endtask
    task automatic exec(logic [15:0] w, logic [2:0] bpp, logic [15:0] st);
        instr(w);
        check("exec", 32'({instr_exec, compat_mode, byte_op, stack_push, stack_pop, compat_status_word}), 32'({2'b11, bpp, st}));
    endtask
    task automatic trap(logic [15:0] w, logic [15:0] c);
        enter(GOOD, 4'h0);
        instr(w);
        check("trap", {frame_valid, compat_mode, frame_has_code, 13'h0000, frame_code[15:0]}, {3'b101, 13'h0, c});
        check("frame_pc", frame_pc, 32'h00001234);
        $display("trap %h done", w);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        #2000000;
        num_errors++;
        print_verdict();
    end
    initial
    begin
        logic [31:0] bad [6] = '{32'h83C00020, 32'h83C10000, 32'h87C00000, 32'h8BC00000, 32'h82C00000,
            32'h83800000};
        {reset, go, go_psl, go_dly, instr_valid, instr_word, ret_psw_valid, ret_psw} = {1'b1, 71'h0};
        {ea_valid, ea_addr, ea_is_word, exc_req, leg_reg_sel, leg_wr_data, native_rd_data} = '0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (bad[i])
        begin
            enter(bad[i], 4'h0);
            check("fault", 32'({rsvd_operand_fault, compat_mode}), 32'h2);
        end
        enter(32'h03C00000, 4'h0);
        check("ignored", 32'({rsvd_operand_fault, compat_mode}), 32'h0);
        enter(GOOD, 4'h5);
        check("enter", 32'({compat_mode, compat_status_word}), 32'h1000A);
        exec(16'h00B1, 3'b000, 16'h000B);
        exec(16'h00AF, 3'b000, 16'h0000);
        exec(16'h0D40, 3'b010, 16'h0000);
        exec(16'h8D80, 3'b001, 16'h0000);
        exec(16'h8A00, 3'b100, 16'h0000);
        exec(16'h8000, 3'b000, 16'h0000);
        @(posedge sys_clk);
        {ret_psw_valid, ret_psw} <= {1'b1, 16'hFFFF};
        @(posedge sys_clk);
        ret_psw_valid <= 1'b0;
        #1;
        check("ret", 32'(compat_status_word), 32'h001F);
        exec(16'h005F, 3'b000, 16'h001F);
        ea(16'h2000, 1'b1);
        check("jump", 32'({jump_target, virt_addr[15:0]}), 32'h20002000);
        @(posedge sys_clk);
        exc_req <= 1'b1;
        @(posedge sys_clk);
        exc_req <= 1'b0;
        #1;
        check("exit", 32'({frame_valid, frame_has_code, compat_mode}), 32'h4);
        check("psl", frame_psl, 32'h83C0001F);
        $display("compat run done");
        trap(16'h0003, 16'h0001);
        trap(16'h0004, 16'h0002);
        trap(16'h88FF, 16'h0003);
        trap(16'h8900, 16'h0004);
        trap(16'h0005, 16'h0000);
        trap(16'h0098, 16'h0000);
        trap(16'h7A00, 16'h0000);
        trap(16'hF000, 16'h0000);
        trap(16'h0043, 16'h0005);
        enter(32'h83C00010, 4'h1);
        instr(16'h0003);
        check("tp", frame_psl, 32'hC3C00010);
        enter(GOOD, 4'h2);
        ea(16'h1235, 1'b0);
        check("byte", 32'({compat_mode, virt_addr[15:0]}), 32'h00011235);
        check("va_hi", virt_addr, 32'h00001235);
        ea(16'h1235, 1'b1);
        check("odd", 32'({frame_valid, compat_mode, frame_code[15:0]}), 32'h20006);
        for (int s = 6; s < 8; s++)
        begin
            @(posedge sys_clk);
            {leg_reg_sel, native_rd_data, leg_wr_data} <= {3'(s), 32'hABCD1234, 16'h8001};
            repeat (2) @(posedge sys_clk);
            #1;
            check("map", 32'({native_reg_sel, leg_rd_data}), 32'({(s == 7) ? 4'hF : 4'(s), 16'h1234}));
            check("wr", native_wr_data, 32'h00008001);
        end
        $display("mapping done");
        print_verdict();
    end
endmodule // legacy_isa_compat_mode_tb

// ==== verification/lic_compat_properties.sv ====
// Purpose: Port-level checks on the compatibility core
// Assumes: One sys_clk domain, reset async active high
// Notes: Bound to every lic_compat_core instance
module lic_compat_properties
    import lic_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic reset, // Async reset
    input wire logic ce, // Clock enable
    input wire logic rei_valid, // Native return
    input wire logic [31:0] rei_psl, // Popped longword
    input wire logic instr_valid, // Word presented
    input wire logic [15:0] instr_word, // Legacy word
    input wire logic exc_req, // Exception request
    input wire logic ea_valid, // Address valid
    input wire logic [15:0] ea_addr, // Legacy address
    input wire logic compat_mode, // Legacy decoding
    input wire logic [15:0] compat_status_word, // Status word
    input wire logic rsvd_operand_fault, // Entry refused
    input wire logic frame_valid, // Exit frame
    input wire logic [31:0] frame_psl, // Stacked longword
    input wire logic [31:0] frame_code, // Code longword
    input wire logic [31:0] virt_addr // Virtual address
);
    logic take;
    logic psl_ok;
    // Entry request and its field checks
    assign take = ce && rei_valid && rei_psl[31] && !compat_mode;
    assign psl_ok = {rei_psl[27:22], rei_psl[20:5]} == {6'h0F, 16'h0000};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_status_zero: assert property
        (compat_status_word[15:5] == 11'h000) else $error("status upper bits set");
    a_entry_taken: assert property
        (take && psl_ok |=> compat_mode && compat_status_word[4:0] == $past(rei_psl[4:0]))
        else $error("entry not taken");
    a_entry_refused: assert property
        (take && !psl_ok |=> rsvd_operand_fault && !compat_mode) else $error("bad entry accepted");
    a_exit_on_exc: assert property
        (compat_mode && ce && exc_req |=> frame_valid && !compat_mode) else $error("no exit frame");
    a_frame_fields: assert property
        (frame_valid |-> {frame_psl[31], frame_psl[27:22], frame_psl[20:5]} == {1'b1, 6'h0F, 16'h0000})
        else $error("stacked longword fields wrong");
    a_code_upper: assert property
        (frame_valid |-> frame_code[31:16] == 16'h0000) else $error("code upper half set");
    a_bpt_code: assert property
        (compat_mode && ce && instr_valid && instr_word == 16'h0003 && !exc_req && !ea_valid
        |=> frame_valid && frame_code[15:0] == TRAP_BPT) else $error("breakpoint code wrong");
    a_virt_map: assert property
        (ce && ea_valid |=> virt_addr == {16'h0000, $past(ea_addr)}) else $error("address map wrong");
endmodule // lic_compat_properties
bind lic_compat_core lic_compat_properties u_props (.sys_clk, .reset, .ce, .rei_valid, .rei_psl,
    .instr_valid, .instr_word, .exc_req, .ea_valid, .ea_addr, .compat_mode, .compat_status_word,
    .rsvd_operand_fault, .frame_valid, .frame_psl, .frame_code, .virt_addr);

// ==== verification/lic_exec_model.sv ====
// Purpose: Native executive returning into compatibility mode
// Assumes: Requests come from the bench on sys_clk
// Notes: Reply delay is chosen per request
module lic_exec_model
(
    input wire logic sys_clk, // Clock
    input wire logic go, // Request a return
    input wire logic [31:0] go_psl, // Longword image to pop
    input wire logic [3:0] go_dly, // Extra wait cycles
    output logic rei_valid, // Return executing
    output logic [31:0] rei_psl // Popped image
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pop the image after the chosen delay
    initial
    begin
        rei_valid = 1'b0;
        rei_psl = 32'h00000000;
    end
    always @(posedge sys_clk)
    begin
        if (go)
        begin
            repeat (go_dly) @(posedge sys_clk);
            rei_valid <= 1'b1;
            rei_psl <= go_psl;
            @(posedge sys_clk);
            rei_valid <= 1'b0;
            rei_psl <= ~go_psl; // Stale image not held
        end
    end
endmodule // lic_exec_model
